/* File: vp_regs_pkg.sv */
// Register map, field positions and reset values of the video port
// status and interrupt enable bank.
// Assumes a 32-bit APB slave with one aligned word per register.
package vp_regs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_STATUS_OFS = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_OFS  = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h08;
  localparam int         ADDR_W          = 8;

  // ----------------------------------------------------------------
  // Port status fields
  // ----------------------------------------------------------------
  localparam int DC_DISABLE_BIT = 3;
  localparam int HIGH_HALF_BIT  = 2;

  // ----------------------------------------------------------------
  // Interrupt enable / event fields (same layout in both registers, GLOBAL_EN_BIT in enable only)
  // ----------------------------------------------------------------
  localparam int LONG_FIELD_B_BIT    = 23;
  localparam int SHORT_FIELD_B_BIT   = 22;
  localparam int VERT_F2_B_BIT       = 21;
  localparam int VERT_F1_B_BIT       = 20;
  localparam int SYNC_ERR_B_BIT      = 19;
  localparam int CAP_DONE_B_BIT      = 18;
  localparam int CAP_OVR_B_BIT       = 17;
  localparam int GPIO_EVT_BIT        = 16;
  localparam int DISP_UNACK_BIT      = 14;
  localparam int DISP_DONE_BIT       = 13;
  localparam int DISP_UNDER_BIT      = 12;
  localparam int SYSTIME_TICK_BIT    = 11;
  localparam int SYSTIME_EVT_BIT     = 10;
  localparam int LONG_FIELD_A_BIT    = 7;
  localparam int SHORT_FIELD_A_BIT   = 6;
  localparam int VERT_F2_A_BIT       = 5;
  localparam int VERT_F1_A_BIT       = 4;
  localparam int SYNC_ERR_A_BIT      = 3;
  localparam int CAP_DONE_A_BIT      = 2;
  localparam int CAP_OVR_A_BIT       = 1;
  localparam int GLOBAL_EN_BIT       = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] IRQ_ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] IRQ_STATUS_RST = 32'h0000_0000;
  localparam int          STRAP_SETTLE   = 3;

endpackage

/* File: strap_capture.sv */
// Strap capture for the chip-level pin-mux configuration levels.
// Assumes the strap levels are asynchronous to mclk and steady
// around reset release.
`timescale 1ns/1ps
`default_nettype none

module strap_capture #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] strapIn,
  output logic      [WIDTH-1:0] strapOut,
  output logic                  captured
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;
  logic [1:0]       settle_reg;
  logic [1:0]       settle_next;
  logic             done_reg;
  logic             done_next;

  // ----------------------------------------------------------------
  // Capture: wait for the synchroniser to fill, then latch once
  // ----------------------------------------------------------------
  always_comb begin
    hold_next   = hold_reg;
    settle_next = settle_reg;
    done_next   = done_reg;
    if (!done_reg) begin
      if (settle_reg == 2'(vp_regs_pkg::STRAP_SETTLE - 1)) begin
        hold_next = sync_reg;
        done_next = 1'b1;
      end else begin
        settle_next = settle_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg   <= '0;
      sync_reg   <= '0;
      hold_reg   <= '0;
      settle_reg <= 2'h0;
      done_reg   <= 1'b0;
    end else begin
      meta_reg   <= strapIn;
      sync_reg   <= meta_reg;
      hold_reg   <= hold_next;
      settle_reg <= settle_next;
      done_reg   <= done_next;
    end
  end

  assign strapOut = hold_reg;
  assign captured = done_reg;

endmodule

`default_nettype wire

/* File: vp_status_irq.sv */
// Video port status and interrupt enable register bank, APB slave.
// Assumes event pulses come from logic on mclk and the pin-mux straps
// come from chip pins, asynchronous to mclk.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module vp_status_irq (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [23:0] eventIn,
  input  wire logic        dcDisableStrap,
  input  wire logic        highHalfStrap,
  output logic             dualChannelDisable,
  output logic             highHalfInUse,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Field masks
  // ----------------------------------------------------------------
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] EVT_MASK =
      (ONE << vp_regs_pkg::LONG_FIELD_B_BIT)  |
      (ONE << vp_regs_pkg::SHORT_FIELD_B_BIT) |
      (ONE << vp_regs_pkg::VERT_F2_B_BIT)     |
      (ONE << vp_regs_pkg::VERT_F1_B_BIT)     |
      (ONE << vp_regs_pkg::SYNC_ERR_B_BIT)    |
      (ONE << vp_regs_pkg::CAP_DONE_B_BIT)    |
      (ONE << vp_regs_pkg::CAP_OVR_B_BIT)     |
      (ONE << vp_regs_pkg::GPIO_EVT_BIT)      |
      (ONE << vp_regs_pkg::DISP_UNACK_BIT)    |
      (ONE << vp_regs_pkg::DISP_DONE_BIT)     |
      (ONE << vp_regs_pkg::DISP_UNDER_BIT)    |
      (ONE << vp_regs_pkg::SYSTIME_TICK_BIT)  |
      (ONE << vp_regs_pkg::SYSTIME_EVT_BIT)   |
      (ONE << vp_regs_pkg::LONG_FIELD_A_BIT)  |
      (ONE << vp_regs_pkg::SHORT_FIELD_A_BIT) |
      (ONE << vp_regs_pkg::VERT_F2_A_BIT)     |
      (ONE << vp_regs_pkg::VERT_F1_A_BIT)     |
      (ONE << vp_regs_pkg::SYNC_ERR_A_BIT)    |
      (ONE << vp_regs_pkg::CAP_DONE_A_BIT)    |
      (ONE << vp_regs_pkg::CAP_OVR_A_BIT);
  localparam logic [31:0] IE_MASK =
      EVT_MASK | (ONE << vp_regs_pkg::GLOBAL_EN_BIT);
  localparam logic [31:0] STAT_MASK =
      (ONE << vp_regs_pkg::DC_DISABLE_BIT) |
      (ONE << vp_regs_pkg::HIGH_HALF_BIT);

  logic [31:0] irqEnable_reg;
  logic [31:0] irqEnable_next;
  logic [31:0] irqStatus_reg;
  logic [31:0] irqStatus_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        err_reg;
  logic        err_next;
  logic        irq_reg;
  logic        irq_next;
  logic [1:0]  strapLevel;
  logic        strapDone;
  logic        setupPhase;
  logic        wrAccess;
  logic        hitStatus;
  logic        hitEnable;
  logic        hitIrqStat;
  logic [31:0] portStatus;
  logic [31:0] eventWide;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  strap_capture #(
    .WIDTH (2)
  ) u_strap (
    .mclk     (mclk),
    .rst      (rst),
    .strapIn  ({dcDisableStrap, highHalfStrap}),
    .strapOut (strapLevel),
    .captured (strapDone)
  );

  // Straps, not constants, set the flag; 1 means dual channel forbidden
  assign dualChannelDisable = strapLevel[1];
  // High half can never show without the disable flag
  assign highHalfInUse = strapLevel[0] & strapLevel[1];

  // Only reported to software: nothing here routes video data by it
  always_comb begin
    portStatus = 32'h0000_0000;
    portStatus[vp_regs_pkg::DC_DISABLE_BIT] = dualChannelDisable;
    portStatus[vp_regs_pkg::HIGH_HALF_BIT]  = highHalfInUse;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setupPhase = psel & ~penable;
  assign wrAccess   = psel & penable & pwrite;
  assign hitStatus  = paddr == vp_regs_pkg::PORT_STATUS_OFS;
  assign hitEnable  = paddr == vp_regs_pkg::IRQ_ENABLE_OFS;
  assign hitIrqStat = paddr == vp_regs_pkg::IRQ_STATUS_OFS;
  assign eventWide  = {8'h00, eventIn} & EVT_MASK;

  // Zero wait states: read data is staged during the setup cycle
  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = err_reg & psel & penable;

  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setupPhase) begin
      rdata_next = 32'h0000_0000;
      err_next   = ~(hitStatus | hitEnable | hitIrqStat);
      if (!pwrite) begin
        unique case (1'b1)
          hitStatus:  rdata_next = portStatus;
          hitEnable:  rdata_next = irqEnable_reg & IE_MASK;
          hitIrqStat: rdata_next = irqStatus_reg & EVT_MASK;
          default:    rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable and sticky event registers
  // ----------------------------------------------------------------
  always_comb begin
    irqEnable_next = irqEnable_reg;
    irqStatus_next = irqStatus_reg;
    if (wrAccess && hitEnable) begin
      irqEnable_next = pwdata & IE_MASK;
    end
    if (wrAccess && hitIrqStat) begin
      irqStatus_next = irqStatus_reg & ~pwdata;
    end
    // A new event wins over a same-cycle clear
    irqStatus_next = (irqStatus_next | eventWide) & EVT_MASK;
  end

  // Global enable must be set as well as the per-event enable
  always_comb begin
    irq_next = irqEnable_reg[vp_regs_pkg::GLOBAL_EN_BIT] &
               |(irqStatus_reg & irqEnable_reg & EVT_MASK);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqEnable_reg <= vp_regs_pkg::IRQ_ENABLE_RST;
      irqStatus_reg <= vp_regs_pkg::IRQ_STATUS_RST;
      rdata_reg     <= 32'h0000_0000;
      err_reg       <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      irqEnable_reg <= irqEnable_next;
      irqStatus_reg <= irqStatus_next;
      rdata_reg     <= rdata_next;
      err_reg       <= err_next;
      irq_reg       <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reserved_zero: assert property (
    @(posedge mclk) disable iff (rst)
    ((irqEnable_reg & ~IE_MASK) == 32'h0000_0000) &&
    ((portStatus & ~STAT_MASK) == 32'h0000_0000))
    else $error("reserved bits not zero");

  chk_strap_steady: assert property (
    @(posedge mclk) disable iff (rst)
    strapDone |=> $stable(dualChannelDisable) && $stable(highHalfInUse))
    else $error("strap flag changed after capture");

  chk_status_read: assert property (
    @(posedge mclk) disable iff (rst)
    (setupPhase && !pwrite && hitStatus) |=>
    prdata[vp_regs_pkg::DC_DISABLE_BIT] == $past(dualChannelDisable) &&
    prdata[vp_regs_pkg::HIGH_HALF_BIT] == $past(highHalfInUse))
    else $error("status read mismatch");

  chk_high_needs_dc: assert property (
    @(posedge mclk) disable iff (rst)
    highHalfInUse |-> dualChannelDisable)
    else $error("high half without disable flag");

  chk_status_ro: assert property (
    @(posedge mclk) disable iff (rst)
    (wrAccess && hitStatus && strapDone) |=>
    $stable(dualChannelDisable) && $stable(irqEnable_reg))
    else $error("write to status had an effect");

  chk_enable_write: assert property (
    @(posedge mclk) disable iff (rst)
    (wrAccess && hitEnable) |=> irqEnable_reg == ($past(pwdata) & IE_MASK))
    else $error("enable write not stored");

  chk_enable_read: assert property (
    @(posedge mclk) disable iff (rst)
    (setupPhase && !pwrite && hitEnable) ##1 (psel && penable) |->
    prdata == irqEnable_reg)
    else $error("enable readback mismatch");

  chk_irq_gate: assert property (
    @(posedge mclk) disable iff (rst)
    ##1 irq == $past(|(irqStatus_reg & irqEnable_reg & EVT_MASK) &&
                    irqEnable_reg[vp_regs_pkg::GLOBAL_EN_BIT]))
    else $error("interrupt output not gated by enables");

  chk_global_off: assert property (
    @(posedge mclk) disable iff (rst)
    !irqEnable_reg[vp_regs_pkg::GLOBAL_EN_BIT] [*2] |-> !irq)
    else $error("interrupt with global enable off");

  chk_event_sticky: assert property (
    @(posedge mclk) disable iff (rst)
    (eventWide != 32'h0000_0000) |=>
    (irqStatus_reg & $past(eventWide)) == $past(eventWide))
    else $error("event lost");

  chk_unmapped_err: assert property (
    @(posedge mclk) disable iff (rst)
    (setupPhase && !(hitStatus || hitEnable || hitIrqStat)) ##1
    (psel && penable) |-> pslverr)
    else $error("unmapped access without error");

  chk_mapped_ok: assert property (
    @(posedge mclk) disable iff (rst)
    (setupPhase && (hitStatus || hitEnable || hitIrqStat)) ##1
    (psel && penable) |-> !pslverr)
    else $error("mapped access flagged as error");

  chk_status_rsvd: assert property (
    @(posedge mclk) disable iff (rst)
    (setupPhase && !pwrite && hitStatus) |=>
    ((prdata & ~STAT_MASK) == 32'h0000_0000))
    else $error("status reserved bits not zero");

  chk_straps_early: assert property (
    @(posedge mclk) disable iff (rst)
    !strapDone |-> !dualChannelDisable && !highHalfInUse)
    else $error("strap flag shown before capture");

  chk_enable_hold: assert property (
    @(posedge mclk) disable iff (rst)
    !(wrAccess && hitEnable) |=>
    $stable(irqEnable_reg))
    else $error("enable changed without a write");

  chk_clear_w1c: assert property (
    @(posedge mclk) disable iff (rst)
    (wrAccess && hitIrqStat && eventWide == 32'h0000_0000) |=>
    ((irqStatus_reg & $past(pwdata) & EVT_MASK) == 32'h0000_0000))
    else $error("status bit not cleared by a one");

  chk_set_wins: assert property (
    @(posedge mclk) disable iff (rst)
    (wrAccess && hitIrqStat && eventWide != 32'h0000_0000) |=>
    ((irqStatus_reg & $past(eventWide)) == $past(eventWide)))
    else $error("clear beat a same-cycle event");

  chk_irq_low: assert property (
    @(posedge mclk) disable iff (rst)
    ((irqStatus_reg & irqEnable_reg & EVT_MASK) == 32'h0000_0000) |=>
    !irq)
    else $error("interrupt without an enabled event");

  chk_irq_rise: assert property (
    @(posedge mclk) disable iff (rst)
    (irqEnable_reg[vp_regs_pkg::GLOBAL_EN_BIT] &&
     ((irqStatus_reg & irqEnable_reg & EVT_MASK) != 32'h0000_0000)) |=> irq)
    else $error("enabled event did not raise interrupt");

endmodule

`default_nettype wire

/* File: vp_status_irq_bench.sv */
// Self-checking bench for the video port status and interrupt enable bank.
// Assumes the APB slave answers with pready and a 24-bit event input.
`timescale 1ns/1ps
`default_nettype none

module vp_status_irq_bench;

  // ----------------------------------------------------------------
  // Signals and expectations
  // ----------------------------------------------------------------
  localparam logic [31:0] ENABLE_MASK = 32'h00FF7CFF;
  localparam logic [31:0] EVENT_MASK  = 32'h00FF7CFE;

  logic        mclk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [23:0] eventIn;
  logic        dcDisableStrap;
  logic        highHalfStrap;
  logic        dualChannelDisable;
  logic        highHalfInUse;
  logic        irq;
  int          error_cnt;
  int          comparisons;
  int          seed;
  logic [31:0] rdVal;
  logic        rdErr;
  logic [31:0] wrVal;
  logic [31:0] bitVal;

  vp_status_irq DUT (
    .mclk               (mclk),
    .rst                (rst),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .eventIn            (eventIn),
    .dcDisableStrap     (dcDisableStrap),
    .highHalfStrap      (highHalfStrap),
    .dualChannelDisable (dualChannelDisable),
    .highHalfInUse      (highHalfInUse),
    .irq                (irq)
  );

  always #10 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_status(input logic dc, input logic hh);
    exp_status = {28'h0000000, dc, dc & hh, 2'b00};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One transfer; the request is held until pready is seen high
  task automatic apb_xfer(input logic wr, input logic [7:0] addr,
                          input logic [31:0] data, output logic [31:0] rd,
                          output logic err);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    apb_xfer(1'b1, addr, data, rdVal, rdErr);
  endtask

  task automatic rd(input logic [7:0] addr);
    apb_xfer(1'b0, addr, 32'h00000000, rdVal, rdErr);
  endtask

  task automatic pulse(input logic [23:0] ev);
    @(posedge mclk);
    eventIn <= ev;
    @(posedge mclk);
    eventIn <= 24'h000000;
  endtask

  // Straps change only while reset is held, then stay steady
  task automatic do_reset(input logic dc, input logic hh);
    @(posedge mclk);
    rst            <= 1'b1;
    dcDisableStrap <= dc;
    highHalfStrap  <= hh;
    wait_cycles(8);
    rst <= 1'b0;
    wait_cycles(4);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h00000000; eventIn = 24'h000000;
    dcDisableStrap = 1'b0; highHalfStrap = 1'b0;
    error_cnt = 0; comparisons = 0; seed = 2;
    wait_cycles(8);
    rst <= 1'b0;
    wait_cycles(4);
    // Every strap combination, with a reset in mid-run for each
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1], s[0]);
      rd(vp_regs_pkg::PORT_STATUS_OFS);
      check("port_status", rdVal, exp_status(s[1], s[0]));
      check("status err", {31'h0, rdErr}, 32'h00000000);
      check("dc flag", {31'h0, dualChannelDisable}, {31'h0, s[1]});
      check("high half", {31'h0, highHalfInUse}, {31'h0, s[1] & s[0]});
      wr(vp_regs_pkg::PORT_STATUS_OFS, 32'hFFFFFFFF);
      rd(vp_regs_pkg::PORT_STATUS_OFS);
      check("port_status ro", rdVal, exp_status(s[1], s[0]));
      rd(vp_regs_pkg::IRQ_ENABLE_OFS);
      check("irq_enable reset", rdVal, 32'h00000000);
      wr(vp_regs_pkg::IRQ_ENABLE_OFS, 32'hFFFFFFFF);
      rd(vp_regs_pkg::IRQ_ENABLE_OFS);
      check("irq_enable ones", rdVal, ENABLE_MASK);
    end
    // Random write and read back; high half stays informational
    for (int k = 0; k < 8; k++) begin
      wrVal = $random(seed);
      wr(vp_regs_pkg::IRQ_ENABLE_OFS, wrVal);
      rd(vp_regs_pkg::IRQ_ENABLE_OFS);
      check("irq_enable rw", rdVal, wrVal & ENABLE_MASK);
      check("high half held", {31'h0, highHalfInUse}, 32'h00000001);
    end
    // Unmapped place is refused
    rd(8'h0C);
    check("unmapped err", {31'h0, rdErr}, 32'h00000001);
    check("unmapped data", rdVal, 32'h00000000);
    // Each event source, passed and blocked by its own enable bit
    wr(vp_regs_pkg::IRQ_STATUS_OFS, 32'hFFFFFFFF);
    for (int i = 1; i < 24; i++) begin
      if (EVENT_MASK[i]) begin
        bitVal = 32'h00000001 << i;
        wr(vp_regs_pkg::IRQ_ENABLE_OFS, bitVal | 32'h00000001);
        pulse(bitVal[23:0]);
        wait_cycles(3);
        check("irq passed", {31'h0, irq}, 32'h00000001);
        rd(vp_regs_pkg::IRQ_STATUS_OFS);
        check("irq_status", rdVal, bitVal);
        wr(vp_regs_pkg::IRQ_STATUS_OFS, bitVal);
        wait_cycles(2);
        check("irq cleared", {31'h0, irq}, 32'h00000000);
        wr(vp_regs_pkg::IRQ_ENABLE_OFS, ENABLE_MASK & ~bitVal);
        pulse(bitVal[23:0]);
        wait_cycles(3);
        check("irq blocked", {31'h0, irq}, 32'h00000000);
        wr(vp_regs_pkg::IRQ_ENABLE_OFS, ENABLE_MASK);
        wait_cycles(2);
        check("irq unmasked", {31'h0, irq}, 32'h00000001);
        wr(vp_regs_pkg::IRQ_STATUS_OFS, bitVal);
      end
    end
    // An event sampled at the edge of its own clear stays set
    fork
      wr(vp_regs_pkg::IRQ_STATUS_OFS, 32'h00040000);
      begin
        wait_cycles(1);
        pulse(24'h040000);
      end
    join
    rd(vp_regs_pkg::IRQ_STATUS_OFS);
    check("set wins", rdVal, 32'h00040000);
    wr(vp_regs_pkg::IRQ_STATUS_OFS, 32'hFFFFFFFF);
    // Global enable off keeps every source away from irq
    wr(vp_regs_pkg::IRQ_ENABLE_OFS, ENABLE_MASK & ~32'h00000001);
    pulse(EVENT_MASK[23:0]);
    wait_cycles(3);
    check("global off", {31'h0, irq}, 32'h00000000);
    wr(vp_regs_pkg::IRQ_STATUS_OFS, 32'hFFFFFFFF);
    // Events on reserved positions are ignored
    wr(vp_regs_pkg::IRQ_ENABLE_OFS, 32'hFFFFFFFF);
    pulse(24'h008301);
    wait_cycles(3);
    check("reserved events", {31'h0, irq}, 32'h00000000);
    rd(vp_regs_pkg::IRQ_STATUS_OFS);
    check("reserved status", rdVal, 32'h00000000);
    close_out();
  end

  // Cuts a hang short
  initial begin
    wait_cycles(90000);
    error_cnt++;
    close_out();
  end

endmodule

`default_nettype wire
